// ===== verilog/sdfb_pkg.sv
package sdfb_pkg;
  // Frame geometry in bytes
  localparam int FRAME_MAX = 31;
  localparam int HDR_LEN = 13;
  localparam int ENTRY_LEN = 2;
  localparam int MAX_ENTRIES = 9;
  localparam int NUM_ALARMS = 11;
  // Byte positions within the frame
  localparam int POS_SS1 = 0;
  localparam int POS_SS2 = 1;
  localparam int POS_SS3 = 2;
  localparam int POS_MASTER = 3;
  localparam int POS_IDENT_HI = 4;
  localparam int POS_IDENT_LO = 5;
  localparam int POS_IDDIAG = 6;
  localparam int POS_MODSTAT = 8;
  localparam int POS_CHAN = 13;
  // Bit positions inside the station status bytes
  localparam int SS1_GROUP_BIT = 3;
  localparam int SS2_PRM_BIT = 0;
  localparam int SS2_STATIC_BIT = 1;
  localparam int SS2_CFG_BIT = 2;
  localparam int SS2_WD_BIT = 3;
  localparam int SS2_FREEZE_BIT = 4;
  localparam int SS2_SYNC_BIT = 5;
  localparam int SS2_ZERO_BIT = 6;
  localparam int SS2_DEACT_BIT = 7;
  localparam int SS3_OVF_BIT = 7;
  // Alarm slots
  localparam int AL_SHORT = 0;
  localparam int AL_OVERLOAD = 1;
  localparam int AL_OVERTEMP = 2;
  localparam int AL_WIRE = 3;
  localparam int AL_LIM_HI = 4;
  localparam int AL_LIM_LO = 5;
  localparam int AL_INTERNAL = 6;
  localparam int AL_PARAM = 7;
  localparam int AL_SUPPLY = 8;
  localparam int AL_ACTUATOR = 9;
  localparam int AL_EXTERNAL = 10;
  // Five-bit fault type codes
  localparam logic [4:0] FT_SHORT = 5'h01;
  localparam logic [4:0] FT_OVERLOAD = 5'h04;
  localparam logic [4:0] FT_OVERTEMP = 5'h05;
  localparam logic [4:0] FT_WIRE = 5'h06;
  localparam logic [4:0] FT_LIM_HI = 5'h07;
  localparam logic [4:0] FT_LIM_LO = 5'h08;
  localparam logic [4:0] FT_INTERNAL = 5'h09;
  localparam logic [4:0] FT_PARAM = 5'h10;
  localparam logic [4:0] FT_SUPPLY = 5'h11;
  localparam logic [4:0] FT_ACTUATOR = 5'h18;
  localparam logic [4:0] FT_EXTERNAL = 5'h1a;
  // Fixed header bytes and reset values
  localparam logic [7:0] IDDIAG_HDR = 8'h42;
  localparam logic [7:0] MODSTAT_HDR = 8'h05;
  localparam logic [7:0] CHANNEL_NUM = 8'h00;
  localparam logic [10:0] ALARM_RST = 11'h000;
  localparam logic [4:0] LEN_RST = 5'h0d;
  typedef enum {SDFB_IDLE, SDFB_HDR, SDFB_SCAN, SDFB_SEND} sdfb_state_type;
endpackage

// ===== verilog/sdfb_fifo.sv
module sdfb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // Storage words
  logic [AW-1:0] wr_ptr_r;         // Write pointer
  logic [AW-1:0] rd_ptr_r;         // Read pointer
  logic [AW:0] count_r;            // Words held in storage
  logic push;
  logic pop;

  // Output register refills whenever it is empty or being taken
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_r != '0) && (!out_valid || out_ready);

  // Storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered output stage, so the consumer sees flops only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // sdfb_fifo

// ===== verilog/sdfb_builder.sv
// How it works
// R1 - Byte 0 bit 3 flags any pending alarm
// R2 - Byte 1 bit 0 requests new parameterization
// R3 - Static diagnostic sets bit 1, stops operation
// R4 - Bit 2 shows configured, bit 3 monitoring
// R5 - Freeze/sync bits refresh only with other changes
// R6 - Bit 6 zero, bit 7 shows deactivated
// R7 - Byte 2 bits 0-6 zero, bit 7 overflow
// R8 - Byte 3 holds parameterizing master address
// R9 - Bytes 4-5 hold type identifier, high first
// R10 - Identifier diagnostics at byte 6, two bytes
// R11 - Five module status bytes follow directly
// R12 - Channel entries follow; frame at most 31
// R13 - At most nine entries; excess sets overflow
// R14 - Channel entries never alter module status
// R15 - Only current entries rewritten; stale ones kept
// R16 - Every alarm reported on channel zero
// R17 - Codes: short 01, overload 04, overtemp 05
// R18 - Codes: wire 06, limit high 07, low 08
// R19 - Codes: internal 09, parameter 10, supply 11
// R20 - Codes: actuator trip 18, external 1a
// R21 - Short/overtemp latch; overload/wire track cause
// R22 - Trip reset clears parameter, actuator, external
// R23 - Internal error cleared only by restart
// R24 - Supply alarm clears on cause gone or ack
// R25 - Trip reset and restart arrive as pulses
module sdfb_builder #(
  parameter logic [15:0] TYPE_IDENT = 16'h1234,  // Arbitrary value, set per product
  parameter int FIFO_DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [10:0] fault_cause,
  input wire logic trip_reset,
  input wire logic restart_cmd,
  input wire logic auto_ack,
  input wire logic frame_req,
  input wire logic prm_request,
  input wire logic static_diag,
  input wire logic station_configured,
  input wire logic resp_monitor_on,
  input wire logic freeze_rx,
  input wire logic sync_rx,
  input wire logic deactivated,
  input wire logic [7:0] master_addr,
  input wire logic [7:0] module_state,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  output logic [4:0] frame_len,
  output logic build_busy,
  output logic [10:0] alarm_active,
  output logic run_enable
);
  logic [7:0] buf_r [sdfb_pkg::FRAME_MAX];  // Frame image, entries left stale
  sdfb_pkg::sdfb_state_type state_r;        // Builder state
  logic [10:0] alarm_r;                     // Alarm bits
  logic [10:0] cause_q_r;                   // Cause of last cycle, for edges
  logic [10:0] alarm_snap_r;                // Alarms frozen for one frame
  logic [3:0] scan_idx_r;                   // Alarm slot being scanned
  logic [3:0] entry_cnt_r;                  // Entries written this frame
  logic ovf_r;                              // More alarms than entries
  logic [4:0] send_idx_r;                   // Next byte to push
  logic [4:0] len_r;                        // Valid frame length
  logic freeze_sh_r;                        // Freeze bit as last refreshed
  logic sync_sh_r;                          // Sync bit as last refreshed
  logic pend_r;                             // Content changed since last frame
  logic run_r;                              // Normal operation allowed
  logic busy_r;                             // Sequencer away from idle, as a flop
  logic [31:0] content_r;                   // Previous diagnostic content
  logic [31:0] content;                     // Alarms, status levels, address, modules
  logic changed;                            // Content differs from last cycle
  logic start;                              // Frame begins this cycle
  logic push;                               // Byte handed to the FIFO
  logic fifo_in_ready;                      // FIFO has room for a byte
  logic [8:0] fifo_out;                     // Last flag above the data byte

  // Fault code per alarm slot
  // Codes are five bits wide; an entry pads them out to a full byte
  function automatic logic [4:0] fault_code(input logic [3:0] idx);
    unique case (idx)
      4'h0: fault_code = sdfb_pkg::FT_SHORT;      // R17
      4'h1: fault_code = sdfb_pkg::FT_OVERLOAD;   // R17
      4'h2: fault_code = sdfb_pkg::FT_OVERTEMP;   // R17
      4'h3: fault_code = sdfb_pkg::FT_WIRE;       // R18
      4'h4: fault_code = sdfb_pkg::FT_LIM_HI;     // R18
      4'h5: fault_code = sdfb_pkg::FT_LIM_LO;     // R18
      4'h6: fault_code = sdfb_pkg::FT_INTERNAL;   // R19
      4'h7: fault_code = sdfb_pkg::FT_PARAM;      // R19
      4'h8: fault_code = sdfb_pkg::FT_SUPPLY;     // R19
      4'h9: fault_code = sdfb_pkg::FT_ACTUATOR;   // R20
      4'ha: fault_code = sdfb_pkg::FT_EXTERNAL;   // R20
      default: fault_code = 5'h00;                // Slots 11-15 do not exist
    endcase
  endfunction

  // Alarm bits; a new cause always wins over a clear in the same cycle
  // Clears are pulses; a clear held high simply keeps clearing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_r <= sdfb_pkg::ALARM_RST;
      cause_q_r <= sdfb_pkg::ALARM_RST;
    end else begin
      cause_q_r <= fault_cause;
      // Latching: clear needs cause gone and a trip reset pulse
      for (int i = 0; i < sdfb_pkg::NUM_ALARMS; i++) begin
        if (i == sdfb_pkg::AL_SHORT || i == sdfb_pkg::AL_OVERTEMP) begin
          alarm_r[i] <= fault_cause[i] || (alarm_r[i] && !trip_reset); // R21 R25
        end else if (i == sdfb_pkg::AL_INTERNAL) begin
          // Power cycling is the block reset; otherwise restart is the only clear
          alarm_r[i] <= fault_cause[i] || (alarm_r[i] && !restart_cmd); // R23 R25
        end else if (i == sdfb_pkg::AL_PARAM || i == sdfb_pkg::AL_ACTUATOR ||
                     i == sdfb_pkg::AL_EXTERNAL) begin
          // A still present cause keeps the bit set through the trip reset
          alarm_r[i] <= fault_cause[i] || (alarm_r[i] && !trip_reset); // R22
        end else if (i == sdfb_pkg::AL_SUPPLY) begin
          // Raised on onset so an automatic ack can drop it early
          alarm_r[i] <= (fault_cause[i] && !cause_q_r[i]) ||
                        (alarm_r[i] && fault_cause[i] && !auto_ack); // R24
        end else begin
          // Overload, wire break and both current limits follow the cause
          alarm_r[i] <= fault_cause[i];  // R21
        end
      end
    end
  end

  // Normal operation halts while a static diagnostic stands
  // Registered so the run output is a flop; this costs one cycle of lag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else begin
      run_r <= !static_diag;  // R3
    end
  end

  // Everything but freeze and sync counts as diagnostic content
  // Freeze and sync are left out so that they alone never start a frame
  assign content = {alarm_r, prm_request, static_diag, station_configured,
                    resp_monitor_on, deactivated, master_addr, module_state};
  // A frame starts on request or on a pending change, only from idle
  assign changed = (content != content_r);
  assign start = (state_r == sdfb_pkg::SDFB_IDLE) && (frame_req || pend_r);

  // Change tracking and refresh of freeze and sync
  // Cost: a wide compare every cycle, but no per-input change strobes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      content_r <= '0;
      freeze_sh_r <= 1'b0;
      sync_sh_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      content_r <= content;
      // The shadows are what the frame shows for freeze and sync
      if (changed) begin
        freeze_sh_r <= freeze_rx;  // R5
        sync_sh_r <= sync_rx;      // R5
      end
      // A change landing as a frame starts is kept for the next one
      pend_r <= changed || (pend_r && !start);
    end
  end

  // Frame sequencer
  // Idle, header, eleven scan cycles, then bytes out until the last one
  // A request while busy is dropped; a content change stays pending instead
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sdfb_pkg::SDFB_IDLE;
      scan_idx_r <= '0;
      entry_cnt_r <= '0;
      ovf_r <= 1'b0;
      send_idx_r <= '0;
      len_r <= sdfb_pkg::LEN_RST;
      busy_r <= 1'b0;
      alarm_snap_r <= sdfb_pkg::ALARM_RST;
    end else begin
      unique case (state_r)
        sdfb_pkg::SDFB_IDLE: begin
          if (start) begin
            // Alarms frozen so that all bytes of one frame agree
            alarm_snap_r <= alarm_r;
            busy_r <= 1'b1;
            state_r <= sdfb_pkg::SDFB_HDR;
          end
        end
        sdfb_pkg::SDFB_HDR: begin
          // Header bytes except byte 2 are written now; the scan starts afresh
          scan_idx_r <= '0;
          entry_cnt_r <= '0;
          ovf_r <= 1'b0;
          state_r <= sdfb_pkg::SDFB_SCAN;
        end
        sdfb_pkg::SDFB_SCAN: begin
          // One slot per cycle, in slot order
          if (alarm_snap_r[scan_idx_r]) begin
            if (entry_cnt_r < 4'(sdfb_pkg::MAX_ENTRIES)) begin
              entry_cnt_r <= entry_cnt_r + 1'b1;
            end else begin
              // No room left: the entry is dropped, only the flag tells
              ovf_r <= 1'b1;  // R13
            end
          end
          // Last slot scanned: stream from byte zero
          if (scan_idx_r == 4'(sdfb_pkg::NUM_ALARMS - 1)) begin
            state_r <= sdfb_pkg::SDFB_SEND;
            send_idx_r <= '0;
          end else begin
            scan_idx_r <= scan_idx_r + 1'b1;
          end
        end
        sdfb_pkg::SDFB_SEND: begin
          // Length is known once the scan is done; kept until the next frame
          len_r <= 5'(sdfb_pkg::HDR_LEN) + {entry_cnt_r, 1'b0};  // R12 R15
          // Waits on a full FIFO; no byte is skipped or repeated
          if (push) begin
            send_idx_r <= send_idx_r + 1'b1;
            if (fifo_out_last_of(send_idx_r)) begin
              // Busy drops with the last push, not with the last byte out
              busy_r <= 1'b0;
              state_r <= sdfb_pkg::SDFB_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Last byte of the frame being pushed
  // Reads the entry count, which stays put while bytes are sent
  function automatic logic fifo_out_last_of(input logic [4:0] idx);
    fifo_out_last_of = (idx == 5'(sdfb_pkg::HDR_LEN) + {entry_cnt_r, 1'b0} - 5'h01);
  endfunction

  // Frame image writes
  // No reset: every byte that is sent is rewritten before it goes out
  always_ff @(posedge core_clk) begin
    if (state_r == sdfb_pkg::SDFB_HDR) begin
      // Other station status 1 bits belong to the bus interface and stay zero
      buf_r[sdfb_pkg::POS_SS1] <= 8'(|alarm_snap_r) << sdfb_pkg::SS1_GROUP_BIT;  // R1
      // Station status 2: freeze and sync from their shadows, bit 6 zero
      buf_r[sdfb_pkg::POS_SS2] <= {deactivated, 1'b0, sync_sh_r, freeze_sh_r,   // R6 R5
                                   resp_monitor_on, station_configured,           // R4
                                   static_diag, prm_request};                     // R3 R2
      // Address of the master that set us up, as delivered
      buf_r[sdfb_pkg::POS_MASTER] <= master_addr;               // R8
      // Type identifier, high byte first
      buf_r[sdfb_pkg::POS_IDENT_HI] <= TYPE_IDENT[15:8];        // R9
      buf_r[sdfb_pkg::POS_IDENT_LO] <= TYPE_IDENT[7:0];         // R9
      // Identifier diagnostics: fixed header, then one faulty flag
      buf_r[sdfb_pkg::POS_IDDIAG] <= sdfb_pkg::IDDIAG_HDR;      // R10
      buf_r[sdfb_pkg::POS_IDDIAG + 1] <= {7'h00, |alarm_snap_r}; // R10
      buf_r[sdfb_pkg::POS_MODSTAT] <= sdfb_pkg::MODSTAT_HDR;    // R11
      // Module status comes from the module state only, never the entries
      for (int k = 1; k < 5; k++) begin
        buf_r[sdfb_pkg::POS_MODSTAT + k] <= module_state;       // R11 R14
      end
    end
    // Entries rewritten only up to the current count; older bytes remain
    if (state_r == sdfb_pkg::SDFB_SCAN && alarm_snap_r[scan_idx_r] &&
        entry_cnt_r < 4'(sdfb_pkg::MAX_ENTRIES)) begin
      buf_r[5'(sdfb_pkg::POS_CHAN) + {entry_cnt_r, 1'b0}] <= sdfb_pkg::CHANNEL_NUM;  // R16 R15
      buf_r[5'(sdfb_pkg::POS_CHAN + 1) + {entry_cnt_r, 1'b0}] <=
        {3'h0, fault_code(scan_idx_r)};                        // R17 R18 R19 R20
    end
    if (state_r == sdfb_pkg::SDFB_SCAN && scan_idx_r == 4'(sdfb_pkg::NUM_ALARMS - 1)) begin
      // Overflow may be raised by this very slot
      buf_r[sdfb_pkg::POS_SS3] <=
        8'(ovf_r || (alarm_snap_r[scan_idx_r] &&
           entry_cnt_r == 4'(sdfb_pkg::MAX_ENTRIES))) << sdfb_pkg::SS3_OVF_BIT;  // R7 R13
    end
  end

  // Stream bytes into the FIFO; a full FIFO stalls the sequencer
  // The last flag travels with its byte so the reader needs no count
  assign push = (state_r == sdfb_pkg::SDFB_SEND) && fifo_in_ready;

  // A few words of slack let the reader stall without losing bytes
  sdfb_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) sdfb_fifo_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(state_r == sdfb_pkg::SDFB_SEND),
    .in_ready(fifo_in_ready),
    .in_data({fifo_out_last_of(send_idx_r), buf_r[send_idx_r]}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

  // Every output is a flop: the FIFO output stage or a register here
  assign out_data = fifo_out[7:0];
  assign out_last = fifo_out[8];
  assign frame_len = len_r;
  assign build_busy = busy_r;
  assign alarm_active = alarm_r;
  assign run_enable = run_r;

  // Checks run on the core clock and sleep during reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Frame bytes are checked as they are pushed, where the image is final
  group_bit_a: assert property (push && send_idx_r == 5'h00 |->  // R1
    buf_r[0][sdfb_pkg::SS1_GROUP_BIT] == |alarm_snap_r) else $error("group bit wrong");
  ss2_fixed_a: assert property (push && send_idx_r == 5'h01 |->  // R6
    !buf_r[1][sdfb_pkg::SS2_ZERO_BIT]) else $error("ss2 bit 6 set");
  ss3_zero_a: assert property (push && send_idx_r == 5'h02 |->  // R7
    buf_r[2][6:0] == 7'h00) else $error("ss3 low bits set");
  run_stop_a: assert property (static_diag |=> !run_r) else $error("ran during fault"); // R3
  frame_len_a: assert property (state_r == sdfb_pkg::SDFB_SEND |=>  // R12
    len_r <= 5'h1f && len_r == 5'h0d + {entry_cnt_r, 1'b0}) else $error("bad length");
  ovf_cnt_a: assert property (ovf_r |-> entry_cnt_r == 4'h9) else $error("early overflow"); // R13
  latch_hold_a: assert property (alarm_r[sdfb_pkg::AL_SHORT] && !trip_reset |=>  // R21
    alarm_r[sdfb_pkg::AL_SHORT]) else $error("short alarm dropped");
  track_a: assert property (##1 alarm_r[sdfb_pkg::AL_WIRE] ==  // R21
    $past(fault_cause[sdfb_pkg::AL_WIRE])) else $error("wire alarm not tracking");
  trip_clr_a: assert property (trip_reset && !fault_cause[sdfb_pkg::AL_PARAM] |=>  // R22
    !alarm_r[sdfb_pkg::AL_PARAM]) else $error("param alarm not cleared");
  internal_hold_a: assert property (alarm_r[sdfb_pkg::AL_INTERNAL] && !restart_cmd |=>  // R23
    alarm_r[sdfb_pkg::AL_INTERNAL]) else $error("internal alarm dropped");
  freeze_hold_a: assert property (!changed |=> $stable(freeze_sh_r)) else $error("freeze moved"); // R5
  chan_zero_a: assert property (push && send_idx_r >= 5'd13 && send_idx_r[0] |->  // R16
    buf_r[send_idx_r] == 8'h00) else $error("channel not zero");
  // Overflow flag, the remaining clear paths and the overtemp latch
  ovf_flag_a: assert property (push && send_idx_r == 5'h02 |->  // R13
    buf_r[2][sdfb_pkg::SS3_OVF_BIT] == ovf_r) else $error("overflow bit wrong");
  restart_clr_a: assert property (restart_cmd && !fault_cause[sdfb_pkg::AL_INTERNAL] |=>  // R23
    !alarm_r[sdfb_pkg::AL_INTERNAL]) else $error("internal alarm not cleared");
  supply_ack_a: assert property (auto_ack && cause_q_r[sdfb_pkg::AL_SUPPLY] |=>  // R24
    !alarm_r[sdfb_pkg::AL_SUPPLY]) else $error("supply alarm not acknowledged");
  overtemp_hold_a: assert property (alarm_r[sdfb_pkg::AL_OVERTEMP] && !trip_reset |=>  // R21
    alarm_r[sdfb_pkg::AL_OVERTEMP]) else $error("overtemp alarm dropped");

  overflow_c: cover property (state_r == sdfb_pkg::SDFB_SEND && ovf_r);
  frame_done_c: cover property (out_valid && out_ready && out_last);
  stall_c: cover property (state_r == sdfb_pkg::SDFB_SEND && !fifo_in_ready);
  trip_clear_c: cover property (trip_reset && alarm_r[sdfb_pkg::AL_ACTUATOR]);
  supply_ack_c: cover property (auto_ack && alarm_r[sdfb_pkg::AL_SUPPLY]);
endmodule // sdfb_builder

// ===== sim/sdfb_master_model.sv
// Diagnostics reader on the far side of the byte stream
module sdfb_master_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic slow,
  input wire logic hold,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_buf [0:31]; // Received bytes; old tail bytes stay until overwritten
  logic [4:0] idx_r; // Write position inside the current frame
  logic ph_r; // Toggles each cycle to pace slow mode
  int rx_len; // Length of the last complete frame
  int frame_cnt; // Number of complete frames seen

  // Ready only moves just after an edge, so a stall never cuts a byte in half
  assign out_ready = !hold && (!slow || ph_r);

  // Capture accepted bytes; the last byte closes the frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= 5'h00;
      ph_r <= 1'b0;
      rx_len <= 0;
      frame_cnt <= 0;
    end else begin
      ph_r <= !ph_r;
      if (out_valid && out_ready) begin
        rx_buf[idx_r] <= out_data;
        if (out_last) begin
          rx_len <= int'(idx_r) + 1;
          frame_cnt <= frame_cnt + 1;
          idx_r <= 5'h00;
        end else begin
          idx_r <= idx_r + 5'h01;
        end
      end
    end
  end
endmodule // sdfb_master_model

// ===== sim/sdfb_builder_tb.sv
// Self-checking bench for the diagnostics frame builder
module sdfb_builder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] IDENT = 16'h5a3c; // Arbitrary value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [10:0] fault_cause = 11'h000;
  logic trip_reset = 1'b0, restart_cmd = 1'b0, auto_ack = 1'b0, frame_req = 1'b0;
  logic prm_request = 1'b0, static_diag = 1'b0, station_configured = 1'b0;
  logic resp_monitor_on = 1'b0, freeze_rx = 1'b0, sync_rx = 1'b0, deactivated = 1'b0;
  logic [7:0] master_addr = 8'h00, module_state = 8'h00;
  logic slow = 1'b0, hold = 1'b0;
  logic out_valid, out_ready, out_last, build_busy, run_enable;
  logic [7:0] out_data;
  logic [4:0] frame_len;
  logic [10:0] alarm_active;
  logic [10:0] exp_al = 11'h000; // Alarm bits the rules predict
  logic exp_frz = 1'b0, exp_syn = 1'b0; // Freeze and sync bits last refreshed
  logic [4:0] codes [0:10] = '{5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                               5'h10, 5'h11, 5'h18, 5'h1a}; // Fault type per slot
  int n_errors = 0;
  int comparisons = 0;

  // 200 MHz clock
  always #2.5 core_clk = !core_clk;

  sdfb_builder #(.TYPE_IDENT(IDENT), .FIFO_DEPTH(4)) sdfb_builder_inst (
    .core_clk(core_clk), .rst_n(rst_n), .fault_cause(fault_cause),
    .trip_reset(trip_reset), .restart_cmd(restart_cmd), .auto_ack(auto_ack),
    .frame_req(frame_req), .prm_request(prm_request), .static_diag(static_diag),
    .station_configured(station_configured), .resp_monitor_on(resp_monitor_on),
    .freeze_rx(freeze_rx), .sync_rx(sync_rx), .deactivated(deactivated),
    .master_addr(master_addr), .module_state(module_state), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
    .frame_len(frame_len), .build_busy(build_busy), .alarm_active(alarm_active),
    .run_enable(run_enable)
  );

  sdfb_master_model sdfb_master_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .slow(slow), .hold(hold), .out_ready(out_ready)
  );

  // Verdict and end of run
  task finish_test;
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One comparison; four-state equality so unknowns never match
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A bound ran out: count it and close the run
  task timeout;
    chk(32'h0, 32'h1);
    finish_test();
  endtask

  // One-cycle pulse on trip reset, restart, auto ack or frame request
  task strobe(input int k);
    @(negedge core_clk);
    case (k)
      0: trip_reset = 1'b1;
      1: restart_cmd = 1'b1;
      2: auto_ack = 1'b1;
      default: frame_req = 1'b1;
    endcase
    @(negedge core_clk);
    {trip_reset, restart_cmd, auto_ack, frame_req} = 4'h0;
  endtask

  // Wait until auto-started frames have drained and the builder is idle
  task settle;
    int i, quiet;
    quiet = 0;
    for (i = 0; i < 3000 && quiet < 30; i++) begin
      @(negedge core_clk);
      quiet = (!build_busy && !out_valid) ? quiet + 1 : 0;
    end
    if (quiet < 30) timeout();
  endtask

  // Request a frame and compare it byte for byte with the predicted one
  task check_frame;
    logic [7:0] e [0:31];
    int n, ent, i, cnt;
    logic any;
    any = |exp_al;
    e[0] = {4'h0, any, 3'h0};
    e[1] = {deactivated, 1'b0, exp_syn, exp_frz, resp_monitor_on, station_configured,
            static_diag, prm_request};
    e[3] = master_addr;
    e[4] = IDENT[15:8];
    e[5] = IDENT[7:0];
    e[6] = sdfb_pkg::IDDIAG_HDR;
    e[7] = {7'h00, any};
    e[8] = sdfb_pkg::MODSTAT_HDR;
    for (i = 9; i < 13; i++) e[i] = module_state;
    n = 13;
    ent = 0;
    for (i = 0; i < 11; i++) begin
      if (exp_al[i]) begin
        if (ent < 9) begin
          e[n] = 8'h00;
          e[n + 1] = {3'h0, codes[i]};
          n = n + 2;
        end
        ent++;
      end
    end
    e[2] = {ent > 9, 7'h00};
    cnt = sdfb_master_model_inst.frame_cnt;
    strobe(3);
    for (i = 0; i < 2000 && sdfb_master_model_inst.frame_cnt == cnt; i++) @(negedge core_clk);
    if (sdfb_master_model_inst.frame_cnt == cnt) timeout();
    chk(alarm_active, exp_al);
    chk(frame_len, n);
    chk(sdfb_master_model_inst.rx_len, n);
    for (i = 0; i < 3; i++) chk(sdfb_master_model_inst.rx_buf[i], e[i]);
    for (i = 3; i < 6; i++) chk(sdfb_master_model_inst.rx_buf[i], e[i]);
    for (i = 6; i < 13; i++) chk(sdfb_master_model_inst.rx_buf[i], e[i]);
    for (i = 13; i < n; i++) chk(sdfb_master_model_inst.rx_buf[i], e[i]);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    chk(frame_len, 13);
    chk({out_valid, build_busy, alarm_active}, 0);
    settle();
    chk(run_enable, 1);
    // Status levels and addresses
    {prm_request, station_configured, resp_monitor_on, deactivated} = 4'hf;
    master_addr = 8'h7b;
    module_state = 8'ha5;
    settle();
    check_frame();
    // Static fault stops operation; configured, monitoring and deactivated drop
    {static_diag, station_configured, resp_monitor_on, deactivated} = 4'h8;
    settle();
    chk(run_enable, 0);
    check_frame();
    static_diag = 1'b0;
    settle();
    // Freeze alone must not refresh; with another change it must
    freeze_rx = 1'b1;
    settle();
    check_frame();
    sync_rx = 1'b1;
    prm_request = 1'b0;
    {exp_frz, exp_syn} = 2'b11;
    settle();
    check_frame();
    // Every fault at once against a stalled reader: nine entries and overflow
    slow = 1'b1;
    hold = 1'b1;
    fault_cause = 11'h7ff;
    exp_al = 11'h7ff;
    repeat (40) @(negedge core_clk);
    chk(out_valid, 1);
    hold = 1'b0;
    settle();
    check_frame();
    slow = 1'b0;
    // Causes drop: tracked slots and supply clear, latched ones stay
    fault_cause = 11'h001;
    exp_al = 11'h6c5;
    settle();
    check_frame();
    strobe(0);
    exp_al = 11'h041;
    settle();
    check_frame();
    fault_cause = 11'h040;
    strobe(0);
    strobe(1);
    exp_al = 11'h040;
    settle();
    check_frame();
    fault_cause = 11'h000;
    strobe(1);
    exp_al = 11'h000;
    settle();
    check_frame();
    // Supply alarm acknowledged while its cause persists
    fault_cause = 11'h100;
    exp_al = 11'h100;
    settle();
    check_frame();
    strobe(2);
    exp_al = 11'h000;
    settle();
    check_frame();
    finish_test();
  end
endmodule // sdfb_builder_tb
